// ==== bccr_params.svh ====
// constants of the bcd calendar clock: offsets, fields, resets, timing
// included by the divider and top design files; definitions only
`ifndef BCCR_PARAMS_SVH
`define BCCR_PARAMS_SVH
`define BCCR_ADDR_SEC 3'h0
`define BCCR_ADDR_MIN 3'h1
`define BCCR_ADDR_HR 3'h2
`define BCCR_ADDR_WD 3'h3
`define BCCR_ADDR_DOM 3'h4
`define BCCR_ADDR_MON 3'h5
`define BCCR_ADDR_YR 3'h6
`define BCCR_ADDR_CTRL 3'h7
`define BCCR_RST_SEC 8'h00
`define BCCR_RST_MIN 8'h80
`define BCCR_RST_HR 8'h00
`define BCCR_RST_WD 8'h01
`define BCCR_RST_DOM 8'h01
`define BCCR_RST_MON 8'h01
`define BCCR_RST_YR 8'h00
`define BCCR_RST_CTRL 8'h81
`define BCCR_TOP_BIT 7
`define BCCR_CB_BIT 6
`define BCCR_SQW_BIT 6
`define BCCR_PF_BIT 0
`define BCCR_DEV_ID 7'h68
`define BCCR_SEC_MAX 7'h59
`define BCCR_HR_MAX 6'h23
`define BCCR_MON_MAX 5'h12
`define BCCR_YR_MAX 8'h99
`define BCCR_WD_MAX 3'h7
`define BCCR_DAYS_FEB 6'h28
`define BCCR_DAYS_LEAP 6'h29
`define BCCR_DAYS_SHORT 6'h30
`define BCCR_DAYS_FULL 6'h31
`define BCCR_CLK_PERIOD_NS 10
`define BCCR_XTAL_HZ 32768
`define BCCR_WAVE_HZ 512
`define BCCR_DIV_SEC `BCCR_XTAL_HZ
`define BCCR_DIV_WAVE (`BCCR_XTAL_HZ / `BCCR_WAVE_HZ)
`define BCCR_OSC_TIMEOUT_NS 122070
`endif

// ==== bccr_pkg.sv ====
// types of the bcd calendar clock
// no dependencies
`default_nettype none
package bccr_pkg;
  typedef enum logic [8:0] {
    s_idle = 9'h001,
    s_dev = 9'h002,
    s_devack = 9'h004,
    s_word = 9'h008,
    s_wordack = 9'h010,
    s_wdat = 9'h020,
    s_wdatack = 9'h040,
    s_rdat = 9'h080,
    s_rdatack = 9'h100
  } bccr_state_type;
endpackage : bccr_pkg
`default_nettype wire

// ==== bccr_sync2.sv ====
// two-flop synchroniser for levels and toggles
// destination clock only; no reset so it never ties into a reset tree
`timescale 1ns/1ps
`default_nettype none
module bccr_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk)
  begin
    meta_ff <= d;
    q_ff <= meta_ff;
  end
endmodule : bccr_sync2
`default_nettype wire

// ==== bccr_xtal_div.sv ====
// crystal-domain dividers: second toggle, 512hz wave, alive toggle
// reset and halt arrive from the system domain and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "bccr_params.svh"
module bccr_xtal_div #(
  parameter int DIV_SEC = `BCCR_DIV_SEC,
  parameter int DIV_WAVE = `BCCR_DIV_WAVE
) (
  input wire logic crystal_input,
  input wire logic rst_n,
  input wire logic halt,
  output logic sec_tog_ff,
  output logic wave_ff,
  output logic alive_tog_ff
);
  localparam int SW = $clog2(DIV_SEC);
  localparam int WW = $clog2(DIV_WAVE / 2);
  logic [1:0] ctl_s;
  logic [SW-1:0] sec_cnt_ff;
  logic [WW-1:0] wave_cnt_ff;
  bccr_sync2 #(.W(2)) u_ctl_sync (
    .clk(crystal_input),
    .d({rst_n, halt}),
    .q_ff(ctl_s)
  );
  ////////////////////////////////////////////////////////////////////
  // free-running, so a halted clock still proves the crystal alive
  always_ff @(posedge crystal_input)
  begin
    if (!ctl_s[1])
      alive_tog_ff <= 1'b0;
    else
      alive_tog_ff <= ~alive_tog_ff;
  end
  always_ff @(posedge crystal_input)
  begin
    if (!ctl_s[1])
    begin
      sec_cnt_ff <= '0;
      sec_tog_ff <= 1'b0;
    end
    else if (!ctl_s[0])
    begin
      if (sec_cnt_ff == SW'(DIV_SEC - 1))
      begin
        sec_cnt_ff <= '0;
        sec_tog_ff <= ~sec_tog_ff;
      end
      else
        sec_cnt_ff <= sec_cnt_ff + 1'b1;
    end
  end
  always_ff @(posedge crystal_input)
  begin
    if (!ctl_s[1])
    begin
      wave_cnt_ff <= '0;
      wave_ff <= 1'b1;
    end
    else if (!ctl_s[0])
    begin
      if (wave_cnt_ff == WW'(DIV_WAVE / 2 - 1))
      begin
        wave_cnt_ff <= '0;
        wave_ff <= ~wave_ff;
      end
      else
        wave_cnt_ff <= wave_cnt_ff + 1'b1;
    end
  end
endmodule : bccr_xtal_div
`default_nettype wire

// ==== bccr_top.sv ====
// bcd calendar clock: i2c target, eight registers, calendar, pin output
// scl/sda are async pins; crystal_input is its own clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bccr_params.svh"
// Functional notes
// - count all time from the crystal
// - counting starts by itself after reset
// - date rolls at true month length
// - seven time registers plus control, no more
// - pointer wraps from last to first
// - read start snapshots time registers
// - pointer ends at last address plus one
// - answer only target address 1101000
// - bcd ranges, 24-hour clock
// - weekday cycles one to seven
// - halt bit stops all counting
// - oscillator fail flag, write clears
// - century bit toggles at year wrap
// - every fourth year is leap
// - documented power-up register defaults
// - pin gives 512hz or static level
// - pin released after reset
// - wave enable overrides level select
// - power loss flag cleared by time write
module bccr_top #(
  parameter int DIV_SEC = `BCCR_DIV_SEC,
  parameter int OSC_TIMEOUT_CYC = `BCCR_OSC_TIMEOUT_NS / `BCCR_CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic crystal_input,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic wave_or_level_pin_out,
  output logic wave_or_level_pin_oe_n
);
  import bccr_pkg::*;
  localparam int OW = $clog2(OSC_TIMEOUT_CYC) + 1;
  localparam logic [7:0] RST_SEC = `BCCR_RST_SEC;
  localparam logic [7:0] RST_MIN = `BCCR_RST_MIN;
  localparam logic [7:0] RST_HR = `BCCR_RST_HR;
  localparam logic [7:0] RST_WD = `BCCR_RST_WD;
  localparam logic [7:0] RST_DOM = `BCCR_RST_DOM;
  localparam logic [7:0] RST_MON = `BCCR_RST_MON;
  localparam logic [7:0] RST_YR = `BCCR_RST_YR;
  localparam logic [7:0] RST_CTRL = `BCCR_RST_CTRL;

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // no century exception: 2100 counts as leap
  function automatic logic [5:0] month_last(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      5'h02: month_last = leap ? `BCCR_DAYS_LEAP : `BCCR_DAYS_FEB;
      5'h04, 5'h06, 5'h09, 5'h11: month_last = `BCCR_DAYS_SHORT;
      default: month_last = `BCCR_DAYS_FULL;
    endcase
  endfunction : month_last

  ////////////////////////////////////////////////////////////////////
  // register state
  logic [6:0] sec_ff;
  logic halt_ff;
  logic [6:0] min_ff;
  logic of_ff;
  logic [5:0] hr_ff;
  logic ceb_ff;
  logic cb_ff;
  logic [2:0] wd_ff;
  logic [5:0] dom_ff;
  logic [4:0] mon_ff;
  logic [7:0] yr_ff;
  logic lvl_ff;
  logic sqw_ff;
  logic pf_ff;
  logic [7:0] reg_view [0:7];
  logic [7:0] snap_ff [0:6];
  logic [7:0] rd_byte;
  // crossings
  logic [2:0] x_s;
  logic [1:0] pin_s;
  logic sec_tog;
  logic wave;
  logic alive_tog;
  logic sec_d_ff;
  logic alive_d_ff;
  logic tick_pend_ff;
  logic [OW-1:0] osc_cnt_ff;
  logic osc_dead;
  logic adv;
  // calendar carries
  logic sec_w;
  logic min_w;
  logic hr_w;
  logic dom_w;
  logic mon_w;
  logic yr_w;
  logic [7:0] nxt_sec;
  logic [7:0] nxt_min;
  logic [7:0] nxt_hr;
  logic [7:0] nxt_dom;
  logic [7:0] nxt_mon;
  logic [7:0] nxt_yr;
  // serial side
  logic scl_d_ff;
  logic sda_d_ff;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic snap_go;
  bccr_state_type st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] tx_ff;
  logic [2:0] ptr_ff;
  logic rw_ff;
  logic mack_ff;
  logic sda_oe_n_ff;
  logic wr_stb_ff;
  logic [2:0] wr_adr_ff;
  logic [7:0] wr_dat_ff;
  logic pin_oe_n_ff;
  logic pin_out_ff;
  logic sda_out_ff;

  ////////////////////////////////////////////////////////////////////
  // crystal domain and crossings
  bccr_xtal_div #(.DIV_SEC(DIV_SEC), .DIV_WAVE(`BCCR_DIV_WAVE)) u_div (
    .crystal_input(crystal_input),
    .rst_n(rst_n),
    .halt(halt_ff),
    .sec_tog_ff(sec_tog),
    .wave_ff(wave),
    .alive_tog_ff(alive_tog)
  );
  bccr_sync2 #(.W(3)) u_x_sync (
    .clk(clk_sys),
    .d({alive_tog, wave, sec_tog}),
    .q_ff(x_s)
  );
  bccr_sync2 #(.W(2)) u_pin_sync (
    .clk(clk_sys),
    .d({scl_in, sda_in}),
    .q_ff(pin_s)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sec_d_ff <= 1'b0;
      alive_d_ff <= 1'b0;
    end
    else
    begin
      sec_d_ff <= x_s[0];
      alive_d_ff <= x_s[2];
    end
  end

  // tick deferred one cycle past a register write instead of lost
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      tick_pend_ff <= 1'b0;
    else if (x_s[0] != sec_d_ff)
      tick_pend_ff <= 1'b1;
    else if (!wr_stb_ff)
      tick_pend_ff <= 1'b0;
  end
  assign adv = tick_pend_ff && !halt_ff && !wr_stb_ff;

  // watchdog on crystal edges
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      osc_cnt_ff <= '0;
    else if (x_s[2] != alive_d_ff)
      osc_cnt_ff <= '0;
    else if (!osc_dead)
      osc_cnt_ff <= osc_cnt_ff + 1'b1;
  end
  assign osc_dead = (osc_cnt_ff == OW'(OSC_TIMEOUT_CYC));

  ////////////////////////////////////////////////////////////////////
  // calendar
  always_comb
  begin
    sec_w = (sec_ff == `BCCR_SEC_MAX);
    min_w = sec_w && (min_ff == `BCCR_SEC_MAX);
    hr_w = min_w && (hr_ff == `BCCR_HR_MAX);
    dom_w = hr_w && (dom_ff == month_last(mon_ff, yr_ff));
    mon_w = dom_w && (mon_ff == `BCCR_MON_MAX);
    yr_w = mon_w && (yr_ff == `BCCR_YR_MAX);
    nxt_sec = bcd_inc({1'b0, sec_ff});
    nxt_min = bcd_inc({1'b0, min_ff});
    nxt_hr = bcd_inc({2'b00, hr_ff});
    nxt_dom = bcd_inc({2'b00, dom_ff});
    nxt_mon = bcd_inc({3'b000, mon_ff});
    nxt_yr = bcd_inc(yr_ff);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sec_ff <= RST_SEC[6:0];
      halt_ff <= RST_SEC[`BCCR_TOP_BIT];
      min_ff <= RST_MIN[6:0];
      hr_ff <= RST_HR[5:0];
      ceb_ff <= RST_HR[`BCCR_TOP_BIT];
      cb_ff <= RST_HR[`BCCR_CB_BIT];
      wd_ff <= RST_WD[2:0];
      dom_ff <= RST_DOM[5:0];
      mon_ff <= RST_MON[4:0];
      yr_ff <= RST_YR;
      lvl_ff <= RST_CTRL[`BCCR_TOP_BIT];
      sqw_ff <= RST_CTRL[`BCCR_SQW_BIT];
    end
    else if (wr_stb_ff)
    begin
      case (wr_adr_ff)
        `BCCR_ADDR_SEC:
        begin
          sec_ff <= wr_dat_ff[6:0];
          halt_ff <= wr_dat_ff[`BCCR_TOP_BIT];
        end
        `BCCR_ADDR_MIN: min_ff <= wr_dat_ff[6:0];
        `BCCR_ADDR_HR:
        begin
          hr_ff <= wr_dat_ff[5:0];
          ceb_ff <= wr_dat_ff[`BCCR_TOP_BIT];
          cb_ff <= wr_dat_ff[`BCCR_CB_BIT];
        end
        `BCCR_ADDR_WD: wd_ff <= wr_dat_ff[2:0];
        `BCCR_ADDR_DOM: dom_ff <= wr_dat_ff[5:0];
        `BCCR_ADDR_MON: mon_ff <= wr_dat_ff[4:0];
        `BCCR_ADDR_YR: yr_ff <= wr_dat_ff;
        default:
        begin
          lvl_ff <= wr_dat_ff[`BCCR_TOP_BIT];
          sqw_ff <= wr_dat_ff[`BCCR_SQW_BIT];
        end
      endcase
    end
    else if (adv)
    begin
      sec_ff <= sec_w ? 7'h00 : nxt_sec[6:0];
      if (sec_w)
        min_ff <= min_w ? 7'h00 : nxt_min[6:0];
      if (min_w)
        hr_ff <= hr_w ? 6'h00 : nxt_hr[5:0];
      if (hr_w)
      begin
        wd_ff <= (wd_ff == `BCCR_WD_MAX) ? 3'h1 : wd_ff + 3'h1;
        dom_ff <= dom_w ? 6'h01 : nxt_dom[5:0];
      end
      if (dom_w)
        mon_ff <= mon_w ? 5'h01 : nxt_mon[4:0];
      if (mon_w)
        yr_ff <= yr_w ? 8'h00 : nxt_yr;
      if (yr_w && ceb_ff)
        cb_ff <= ~cb_ff;
    end
  end

  // a dead crystal beats a clearing write in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      of_ff <= RST_MIN[`BCCR_TOP_BIT];
    else if (osc_dead)
      of_ff <= 1'b1;
    else if (wr_stb_ff && wr_adr_ff == `BCCR_ADDR_MIN && !wr_dat_ff[`BCCR_TOP_BIT])
      of_ff <= 1'b0;
  end

  // only reset sets it; software clears it by writing any time register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pf_ff <= RST_CTRL[`BCCR_PF_BIT];
    else if (wr_stb_ff && wr_adr_ff != `BCCR_ADDR_CTRL)
      pf_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // register view and snapshot
  always_comb
  begin
    reg_view[0] = {halt_ff, sec_ff};
    reg_view[1] = {of_ff, min_ff};
    reg_view[2] = {ceb_ff, cb_ff, hr_ff};
    reg_view[3] = {5'h00, wd_ff};
    reg_view[4] = {2'h0, dom_ff};
    reg_view[5] = {3'h0, mon_ff};
    reg_view[6] = yr_ff;
    reg_view[7] = {lvl_ff, sqw_ff, 5'h00, pf_ff};
  end

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 7; i++)
    begin
      if (!rst_n)
        snap_ff[i] <= 8'h00;
      else if (snap_go)
        snap_ff[i] <= reg_view[i];
    end
  end
  assign rd_byte = (ptr_ff == `BCCR_ADDR_CTRL) ? reg_view[7] : snap_ff[ptr_ff];

  ////////////////////////////////////////////////////////////////////
  // serial target
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= pin_s[1];
      sda_d_ff <= pin_s[0];
    end
  end
  assign start = pin_s[1] && scl_d_ff && sda_d_ff && !pin_s[0];
  assign stop = pin_s[1] && scl_d_ff && !sda_d_ff && pin_s[0];
  assign rise = pin_s[1] && !scl_d_ff;
  assign fall = !pin_s[1] && scl_d_ff;
  assign snap_go = fall && st_ff == s_dev && cnt_ff == 4'h8
                   && sh_ff[7:1] == `BCCR_DEV_ID && sh_ff[0];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_ff <= s_idle;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= `BCCR_ADDR_SEC;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      wr_stb_ff <= 1'b0;
      wr_adr_ff <= `BCCR_ADDR_SEC;
      wr_dat_ff <= 8'h00;
    end
    else
    begin
      wr_stb_ff <= 1'b0;
      if (start)
      begin
        st_ff <= s_dev;
        cnt_ff <= 4'h0;
        sda_oe_n_ff <= 1'b1;
      end
      else if (stop)
      begin
        st_ff <= s_idle;
        sda_oe_n_ff <= 1'b1;
      end
      else if (rise)
      begin
        sh_ff <= {sh_ff[6:0], pin_s[0]};
        cnt_ff <= cnt_ff + 4'h1;
        mack_ff <= !pin_s[0];
      end
      else if (fall)
      begin
        case (st_ff)
          s_dev:
            if (cnt_ff == 4'h8)
            begin
              if (sh_ff[7:1] == `BCCR_DEV_ID)
              begin
                st_ff <= s_devack;
                sda_oe_n_ff <= 1'b0;
                rw_ff <= sh_ff[0];
              end
              else
                st_ff <= s_idle;
            end
          s_devack, s_rdatack:
          begin
            cnt_ff <= 4'h0;
            if (st_ff == s_devack ? rw_ff : mack_ff)
            begin
              tx_ff <= rd_byte;
              sda_oe_n_ff <= rd_byte[7];
              ptr_ff <= ptr_ff + 3'h1;
              st_ff <= s_rdat;
            end
            else if (st_ff == s_devack)
            begin
              sda_oe_n_ff <= 1'b1;
              st_ff <= s_word;
            end
            else
              st_ff <= s_idle;
          end
          s_word:
            if (cnt_ff == 4'h8)
            begin
              ptr_ff <= sh_ff[2:0];
              sda_oe_n_ff <= 1'b0;
              st_ff <= s_wordack;
            end
          s_wordack, s_wdatack:
          begin
            sda_oe_n_ff <= 1'b1;
            cnt_ff <= 4'h0;
            st_ff <= s_wdat;
          end
          s_wdat:
            if (cnt_ff == 4'h8)
            begin
              wr_stb_ff <= 1'b1;
              wr_adr_ff <= ptr_ff;
              wr_dat_ff <= sh_ff;
              ptr_ff <= ptr_ff + 3'h1;
              sda_oe_n_ff <= 1'b0;
              st_ff <= s_wdatack;
            end
          s_rdat:
            if (cnt_ff == 4'h8)
            begin
              sda_oe_n_ff <= 1'b1;
              st_ff <= s_rdatack;
            end
            else
            begin
              sda_oe_n_ff <= tx_ff[6];
              tx_ff <= {tx_ff[6:0], 1'b0};
            end
          default: st_ff <= s_idle;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // open-drain outputs; oe_n low pulls the wire low
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_oe_n_ff <= 1'b1;
      pin_out_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end
    else
    begin
      pin_oe_n_ff <= sqw_ff ? x_s[1] : lvl_ff;
      pin_out_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end
  end
  assign wave_or_level_pin_oe_n = pin_oe_n_ff;
  assign wave_or_level_pin_out = pin_out_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign sda_out = sda_out_ff;

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_sec_wrap;
    adv && sec_w |=> sec_ff == 7'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");
  property p_month_len;
    adv && hr_w && mon_ff == 5'h04 && dom_ff == 6'h30 |=> dom_ff == 6'h01 && mon_ff == 5'h05;
  endproperty
  a_month_len: assert property (p_month_len) else $error("short month wrong");
  property p_leap;
    adv && hr_w && mon_ff == 5'h02 && dom_ff == 6'h28 && yr_ff == 8'h00 |=> dom_ff == 6'h29;
  endproperty
  a_leap: assert property (p_leap) else $error("leap day skipped");
  property p_wd;
    adv && hr_w && wd_ff == 3'h7 |=> wd_ff == 3'h1;
  endproperty
  a_wd: assert property (p_wd) else $error("weekday did not wrap");
  property p_cb;
    adv && yr_w && ceb_ff |=> cb_ff != $past(cb_ff) && yr_ff == 8'h00;
  endproperty
  a_cb: assert property (p_cb) else $error("century bit not toggled");
  property p_halt;
    halt_ff && !wr_stb_ff |=> $stable(sec_ff) && $stable(min_ff);
  endproperty
  a_halt: assert property (p_halt) else $error("counting while halted");
  property p_pf;
    wr_stb_ff && wr_adr_ff != 3'h7 |=> !pf_ff;
  endproperty
  a_pf: assert property (p_pf) else $error("power flag not cleared");
  property p_of;
    osc_dead |=> of_ff;
  endproperty
  a_of: assert property (p_of) else $error("fail flag not set");
  property p_ptr;
    fall && st_ff == s_wdat && cnt_ff == 4'h8 && ptr_ff == 3'h7 |=> ptr_ff == 3'h0 && wr_stb_ff;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer did not wrap");
  property p_pin;
    !sqw_ff && !lvl_ff |=> !wave_or_level_pin_oe_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not pulled low");
  property p_snap;
    snap_go |=> snap_ff[0] == $past(reg_view[0]);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot missed");
  property p_id;
    fall && st_ff == s_dev && cnt_ff == 4'h8 && sh_ff[7:1] != 7'h68
      |=> st_ff == s_idle && sda_oe_n_ff [*2];
  endproperty
  a_id: assert property (p_id) else $error("foreign address acked");
  c_day: cover property (adv && hr_w);
  c_write: cover property (wr_stb_ff);
  c_read: cover property (fall && st_ff == s_rdatack && mack_ff);
  c_year: cover property (adv && yr_w);
endmodule : bccr_top
`default_nettype wire

// ==== bccr_i2c_master.sv ====
// i2c bus master model for the calendar clock's serial pins
// assumes one sda wire with pull-up; this master alone drives scl
`timescale 1ns/1ps
`default_nettype none
module bccr_i2c_master (
  input wire logic clk_sys,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda_in
);
  logic sda_m;
  // wired-and with pull-up: a released line reads high
  assign sda_in = sda_m & (sda_oe_n | sda_out);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // changes land 1ns after an edge, never on it
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  // sda moves mid-low, 4 cycles after scl falls, never while scl high
  task automatic bit_io(input logic v, output logic s);
    sda_m = v;
    wt(4);
    scl = 1'b1;
    wt(8);
    s = sda_in;
    scl = 1'b0;
    wt(4);
  endtask : bit_io
  task automatic start;
    sda_m = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_m = 1'b0;
    wt(8);
    scl = 1'b0;
    wt(4);
  endtask : start
  task automatic stop;
    sda_m = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(8);
    sda_m = 1'b1;
    wt(8);
  endtask : stop
  // msb first, ninth clock left to the target
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send
  // last byte gets a nack so the target lets go
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask : recv
endmodule : bccr_i2c_master
`default_nettype wire

// ==== bcd_calendar_clock_regs_test.sv ====
// self-checking bench for the bcd calendar clock
// assumes bccr_top and the i2c master model; crystal period 64ns
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module bcd_calendar_clock_regs_test;
  logic clk_sys, rst_n, crystal_input, xtal_run, scl_in, sda_in, sda_out, sda_oe_n;
  logic pin_out, pin_oe_n, ack, prev;
  int n_errors, check_count, cycles, n;
  logic [7:0] q[$];
  logic [7:0] d[$];
  logic [7:0] dflt[8] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h81};
  // sec min hr wd dom mon yr, before and after one tick
  logic [55:0] cal_in[6] = '{56'h5959A3072802_99, 56'h59592303280200,
    56'h59592302300424, 56'h5959E305311299, 56'h59596307311299, 56'h59592301290204};
  logic [55:0] cal_exp[6] = '{56'h000080010103_99, 56'h00000004290200,
    56'h00000003010524, 56'h00008006010100, 56'h00004001010100, 56'h00000002010304};
  bccr_top #(.DIV_SEC(1024), .OSC_TIMEOUT_CYC(64)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .crystal_input(crystal_input), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wave_or_level_pin_out(pin_out), .wave_or_level_pin_oe_n(pin_oe_n));
  bccr_i2c_master m (.clk_sys(clk_sys), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl(scl_in), .sda_in(sda_in));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // crystal unrelated in phase; xtal_run lets it die
  initial
  begin
    crystal_input = 1'b0;
    xtal_run = 1'b1;
    #7;
    forever
    begin
      #32;
      if (xtal_run)
        crystal_input = ~crystal_input;
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic tx(input logic [7:0] b);
    logic k;
    m.send(b, k);
    `CHK("ack", 1'b1, k)
  endtask : tx
  task automatic wr(input logic [7:0] a, input logic [7:0] v[$]);
    m.start();
    tx(8'hD0);
    tx(a);
    foreach (v[i]) tx(v[i]);
    m.stop();
  endtask : wr
  // cur skips the address phase: current-address read
  task automatic rd(input logic [7:0] a, input int cnt, input logic cur, output logic [7:0] r[$]);
    logic [7:0] b;
    r = {};
    if (!cur)
    begin
      m.start();
      tx(8'hD0);
      tx(a);
    end
    m.start();
    tx(8'hD1);
    for (int i = 0; i < cnt; i++)
    begin
      m.recv(i == cnt - 1, b);
      r.push_back(b);
    end
    m.stop();
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    rst_n = 1'b0;
    // longer than 20 cycles: crystal side needs three edges of reset
    repeat (24) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    `CHK("pin after reset", 1'b1, pin_oe_n)
    `CHK("pin out", 1'b0, pin_out)
    rd(8'h00, 8, 1'b0, q);
    for (int i = 0; i < 8; i++) `CHK("default", dflt[i], q[i])
    rd(8'h00, 1, 1'b1, q);
    `CHK("wrapped read", 8'h00, q[0])
    wr(8'h07, '{8'h00, 8'h80});
    repeat (10) @(posedge clk_sys);
    `CHK("pin low", 1'b0, pin_oe_n)
    rd(8'h00, 1, 1'b1, q);
    `CHK("next reg", 8'h80, q[0])
    repeat (7000) @(posedge clk_sys);
    rd(8'h00, 1, 1'b0, q);
    `CHK("halted", 8'h80, q[0])
    for (int c = 0; c < 6; c++)
    begin
      // halted while loading, so no tick lands between bytes
      d = {};
      for (int k = 1; k < 7; k++) d.push_back(cal_in[c][55-8*k -: 8]);
      wr(8'h00, '{8'h80});
      wr(8'h01, d);
      wr(8'h00, '{cal_in[c][55:48]});
      repeat (7000) @(posedge clk_sys);
      rd(8'h00, 7, 1'b0, q);
      `CHK("seconds", 7'h00, q[0][7:1])
      for (int k = 1; k < 7; k++) `CHK("calendar", cal_exp[c][55-8*k -: 8], q[k])
    end
    wr(8'h07, '{8'hFF});
    rd(8'h07, 1, 1'b0, q);
    `CHK("control", 8'hC0, q[0])
    // 512hz from a 64ns crystal toggles every 2048ns
    n = 0;
    prev = pin_oe_n;
    repeat (2048)
    begin
      @(posedge clk_sys);
      if (pin_oe_n !== prev)
        n++;
      prev = pin_oe_n;
    end
    `CHK("wave toggles", 1'b1, (n >= 9 && n <= 11))
    wr(8'h07, '{8'h80});
    repeat (10) @(posedge clk_sys);
    `CHK("pin released", 1'b1, pin_oe_n)
    m.start();
    m.send(8'hA0, ack);
    `CHK("foreign id", 1'b0, ack)
    m.stop();
    xtal_run = 1'b0;
    repeat (200) @(posedge clk_sys);
    xtal_run = 1'b1;
    repeat (20) @(posedge clk_sys);
    rd(8'h01, 1, 1'b0, q);
    `CHK("osc fail", 1'b1, q[0][7])
    wr(8'h01, '{8'h00});
    rd(8'h01, 1, 1'b0, q);
    `CHK("osc fail cleared", 1'b0, q[0][7])
    test_done();
  end
endmodule : bcd_calendar_clock_regs_test
`default_nettype wire
